// ===== include/vpic_consts.vh
// constants for the vectored priority interrupt controller
`ifndef VPIC_CONSTS_VH
`define VPIC_CONSTS_VH
// apb register byte offsets
`define VPIC_OFF_REQ0      12'h000
`define VPIC_OFF_REQ1      12'h004
`define VPIC_OFF_REQ2      12'h008
`define VPIC_OFF_LVLH0     12'h00c
`define VPIC_OFF_LVLL0     12'h010
`define VPIC_OFF_LVLH1     12'h014
`define VPIC_OFF_LVLL1     12'h018
`define VPIC_OFF_LVLH2     12'h01c
`define VPIC_OFF_LVLL2     12'h020
`define VPIC_OFF_CTRL      12'h024
`define VPIC_OFF_STAT      12'h028
// control register field
`define VPIC_CTRL_GATE_BIT 7
// reset values
`define VPIC_RST_BYTE      8'h00
// vector slots, in ranking order
`define VPIC_VEC_RESET     16'h0002
`define VPIC_VEC_WDT       16'h0004
`define VPIC_VEC_POSC      16'h003a
`define VPIC_VEC_WOSC      16'h003c
`define VPIC_VEC_ILL       16'h0006
`define VPIC_VEC_T1        16'h000a
`define VPIC_VEC_PA7       16'h0018
`define VPIC_VEC_PC3       16'h0030
`define VPIC_VEC_STEP      16'h0002
`define VPIC_SRC_COUNT     24
`endif

// ===== logic/vpic_ctrl.v
// vectored priority interrupt controller with apb register access
`timescale 1ns/1ns
`include "vpic_consts.vh"

// how the block behaves, in short:
// - every source pulse is latched into its request bit at the next edge;
//   the latch ignores the gate, so software can always poll the bits
// - the level pair of a source is {high bit, low bit}; level zero means
//   the source is disabled and can never win, even when latched
// - watchdog and the three traps have their own latches; they bypass the
//   level registers and the gate and are always offered ahead of any pin
//   or peripheral request
// - one offer at a time: irq_out with vector_out and is_trap_out stand
//   from the edge of the offer until the edge that samples ack_in high
// - the edge that takes an offer drops irq_out; the next winner shows no
//   sooner than one edge later, so a held ack never takes two table vectors
// - taking an interrupt offer clears its request bit and the gate; taking
//   a trap clears only the trap latch, the trap event itself closed the
//   gate already
// - reserved and absent sources are masked at the latch and at the level
//   registers, so neither a pulse nor a software write can raise them
// limitations:
// - the cpu is assumed to raise ack_in only while irq_out is high
// - the winner is chosen from the request state one edge before the
//   offer, so a request that arrives in that cycle waits one extra cycle
// - the reset slot is only the reset value of vector_out, never offered

module vpic_ctrl #(
	parameter [7:0] REQ0_PRESENT = 8'h7b,  // timers, uart, converter
	parameter [7:0] REQ1_PRESENT = 8'hff,  // port A sources
	parameter [7:0] REQ2_PRESENT = 8'h0f   // port C sources
) (
	// clock and reset
	input  wire        clk_in,
	input  wire        rst_n_in,
	// apb slave
	input  wire        psel_in,
	input  wire        penable_in,
	input  wire        pwrite_in,
	input  wire [11:0] paddr_in,
	input  wire [31:0] pwdata_in,
	output wire [31:0] prdata_out,
	output wire        pready_out,
	output wire        pslverr_out,
	// one-cycle source pulses, bit order as request registers
	input  wire [7:0]  req0_pulse_in,
	input  wire [7:0]  req1_pulse_in,
	input  wire [7:0]  req2_pulse_in,
	// watchdog and trap events
	input  wire        wdt_irq_en_in,
	input  wire        wdt_pulse_in,
	input  wire        posc_fail_in,
	input  wire        wosc_fail_in,
	input  wire        ill_instr_in,
	// cpu side
	input  wire        enable_irqs_instruction_in,
	input  wire        disable_irqs_instruction_in,
	input  wire        return_from_isr_instruction_in,
	input  wire        trap_instruction_in,
	input  wire        ack_in,
	output reg         irq_out,
	output reg  [15:0] vector_out,
	output reg         is_trap_out,
	output wire        global_irq_gate_out
);

	// request and level storage, three groups of eight
	reg  [7:0] req_r [0:2];
	reg  [7:0] lvlh_r [0:2];
	reg  [7:0] lvll_r [0:2];
	reg        gate_r;
	reg        wdt_r;
	reg        posc_r;
	reg        wosc_r;
	reg        ill_r;
	reg        pend_r;
	reg  [4:0] win_idx_r;
	reg  [31:0] rdata_r;

	// flattened source view in table order (index 1 = timer 1)
	// index 0 is the reserved top bit of group 0 and is always masked
	wire [23:0] req_flat;
	wire [23:0] lvlh_flat;
	wire [23:0] lvll_flat;
	wire [7:0]  present [0:2];
	assign present[0] = REQ0_PRESENT;
	assign present[1] = REQ1_PRESENT;
	assign present[2] = REQ2_PRESENT;

	// apb decode helpers
	wire wr_en = psel_in & penable_in & pwrite_in;
	wire rd_en = psel_in & ~penable_in & ~pwrite_in;
	wire hit_ctrl = (paddr_in == `VPIC_OFF_CTRL);
	wire hit_stat = (paddr_in == `VPIC_OFF_STAT);

	assign pready_out  = 1'b1;
	assign pslverr_out = 1'b0;
	assign prdata_out  = rdata_r;
	assign global_irq_gate_out = gate_r;

	// register bit b of group g maps to flat index: group0 bit7..0 first
	genvar g, b;
	generate
		for (g = 0; g < 3; g = g + 1) begin : grp
			for (b = 0; b < 8; b = b + 1) begin : bitx
				assign req_flat[g*8 + 7 - b]  = req_r[g][b];
				assign lvlh_flat[g*8 + 7 - b] = lvlh_r[g][b];
				assign lvll_flat[g*8 + 7 - b] = lvll_r[g][b];
			end
		end
	endgenerate

	// ack clears only the bit that was offered
	wire ack_irq = ack_in & pend_r & ~is_trap_out;
	// a watchdog offer has no request bit: its ack must not touch one
	wire ack_req = ack_irq & (vector_out != `VPIC_VEC_WDT);

	// request latches; set wins over software clear and ack
	generate
		for (g = 0; g < 3; g = g + 1) begin : latch
			reg [7:0] pulse;
			reg [7:0] wsel;
			reg [7:0] ackm;
			always @* begin
				pulse = (g == 0) ? req0_pulse_in : (g == 1) ? req1_pulse_in : req2_pulse_in;
				wsel  = 8'h00;
				if (wr_en && paddr_in == `VPIC_OFF_REQ0 + 12'h004 * g)
					wsel = 8'hff;
				ackm  = 8'h00;
				if (ack_req && (win_idx_r >> 3) == g)
					ackm[7 - win_idx_r[2:0]] = 1'b1;
			end
			always @(posedge clk_in) begin
				if (!rst_n_in) begin
					req_r[g]  <= `VPIC_RST_BYTE;
					lvlh_r[g] <= `VPIC_RST_BYTE;
					lvll_r[g] <= `VPIC_RST_BYTE;
				end else begin
					// write 0 clears, write 1 raises, ack clears
					req_r[g] <= ((req_r[g] & ~ackm & ~(wsel & ~pwdata_in[7:0]))
						| (wsel & pwdata_in[7:0]) | pulse) & present[g];
					if (wr_en && paddr_in == `VPIC_OFF_LVLH0 + 12'h008 * g)
						lvlh_r[g] <= pwdata_in[7:0] & present[g];
					if (wr_en && paddr_in == `VPIC_OFF_LVLL0 + 12'h008 * g)
						lvll_r[g] <= pwdata_in[7:0] & present[g];
				end
			end
		end
	endgenerate

	// arbitration: top level first, then lowest flat index
	reg        found;
	reg [4:0]  best_idx;
	reg [1:0]  best_lvl;
	reg [1:0]  lvl;
	integer    i;
	always @* begin
		found    = 1'b0;
		best_idx = 5'd0;
		best_lvl = 2'd0;
		lvl      = 2'd0;
		for (i = 0; i < `VPIC_SRC_COUNT; i = i + 1) begin
			lvl = {lvlh_flat[i], lvll_flat[i]};
			if (req_flat[i] && lvl != 2'd0 && lvl > best_lvl) begin
				found    = 1'b1;
				best_idx = i[4:0];
				best_lvl = lvl;
			end
		end
	end

	// flat index to vector; slot gaps skip reserved entries
	function [15:0] idx_vec;
		input [4:0] idx;
		begin
			// group 0: flat index 1 is timer 1, slot below it is reserved
			if (idx < 5'd8)
				idx_vec = (`VPIC_VEC_T1 - `VPIC_VEC_STEP) + `VPIC_VEC_STEP * {11'h000, idx};
			else if (idx < 5'd16)
				idx_vec = `VPIC_VEC_PA7 + `VPIC_VEC_STEP * {11'h000, idx - 5'd8};
			else
				idx_vec = `VPIC_VEC_PC3 - `VPIC_VEC_STEP * 16'd4
					+ `VPIC_VEC_STEP * {11'h000, idx - 5'd16};
		end
	endfunction

	// watchdog latch; the enable only gates new events, not a held one
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			wdt_r <= 1'b0;
		end else begin
			// a new event in the ack cycle wins and stays latched
			wdt_r <= (wdt_r & ~(ack_in & pend_r & vector_out == `VPIC_VEC_WDT))
				| (wdt_pulse_in & wdt_irq_en_in);
		end
	end

	// primary oscillator fail latch
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			posc_r <= 1'b0;
		end else begin
			posc_r <= (posc_r & ~(ack_in & pend_r & vector_out == `VPIC_VEC_POSC))
				| posc_fail_in;
		end
	end

	// watchdog oscillator fail latch
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			wosc_r <= 1'b0;
		end else begin
			wosc_r <= (wosc_r & ~(ack_in & pend_r & vector_out == `VPIC_VEC_WOSC))
				| wosc_fail_in;
		end
	end

	// illegal instruction latch
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			ill_r <= 1'b0;
		end else begin
			ill_r <= (ill_r & ~(ack_in & pend_r & vector_out == `VPIC_VEC_ILL))
				| ill_instr_in;
		end
	end

	// master gate; clear events win because traps must run masked
	always @(posedge clk_in) begin
		if (!rst_n_in)
			gate_r <= 1'b0;
		else if (disable_irqs_instruction_in || ack_irq || trap_instruction_in
				|| posc_fail_in || wosc_fail_in || ill_instr_in)
			gate_r <= 1'b0;
		else if (wr_en && hit_ctrl)
			gate_r <= pwdata_in[`VPIC_CTRL_GATE_BIT];
		else if (enable_irqs_instruction_in || return_from_isr_instruction_in)
			gate_r <= 1'b1;
	end

	// offer to cpu: hold vector until ack; reset slot is never offered
	// the taking edge always idles one cycle, so a held ack cannot
	// swallow the next table vector before the cpu has seen it
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			pend_r      <= 1'b0;
			irq_out     <= 1'b0;
			is_trap_out <= 1'b0;
			vector_out  <= `VPIC_VEC_RESET;
			win_idx_r   <= 5'd0;
		end else if (pend_r && !ack_in) begin
			// hold the winner stable for the cpu
			pend_r <= 1'b1;
		end else if (pend_r && ack_in) begin
			// offer taken: drop the request line for one cycle
			pend_r  <= 1'b0;
			irq_out <= 1'b0;
		end else if (wdt_r) begin
			// watchdog ranks directly below reset
			pend_r      <= 1'b1;
			irq_out     <= 1'b1;
			is_trap_out <= 1'b0;
			vector_out  <= `VPIC_VEC_WDT;
		end else if (posc_r) begin
			pend_r      <= 1'b1;
			irq_out     <= 1'b1;
			is_trap_out <= 1'b1;
			vector_out  <= `VPIC_VEC_POSC;
		end else if (wosc_r) begin
			pend_r      <= 1'b1;
			irq_out     <= 1'b1;
			is_trap_out <= 1'b1;
			vector_out  <= `VPIC_VEC_WOSC;
		end else if (ill_r) begin
			// illegal instruction trails both oscillator traps
			pend_r      <= 1'b1;
			irq_out     <= 1'b1;
			is_trap_out <= 1'b1;
			vector_out  <= `VPIC_VEC_ILL;
		end else if (gate_r && found && !ack_in) begin
			// table winner; its index is kept so the ack clears its bit
			pend_r      <= 1'b1;
			irq_out     <= 1'b1;
			is_trap_out <= 1'b0;
			win_idx_r   <= best_idx;
			vector_out  <= idx_vec(best_idx);
		end else begin
			// nothing to offer; vector keeps its last value
			pend_r  <= 1'b0;
			irq_out <= 1'b0;
		end
	end

	// read data captured in setup phase, valid in access phase
	always @(posedge clk_in) begin
		if (!rst_n_in)
			rdata_r <= 32'h0000_0000;
		else if (rd_en) begin
			if (paddr_in == `VPIC_OFF_REQ0)
				rdata_r <= {24'h000000, req_r[0]};
			else if (paddr_in == `VPIC_OFF_REQ1)
				rdata_r <= {24'h000000, req_r[1]};
			else if (paddr_in == `VPIC_OFF_REQ2)
				rdata_r <= {24'h000000, req_r[2]};
			else if (paddr_in == `VPIC_OFF_LVLH0)
				rdata_r <= {24'h000000, lvlh_r[0]};
			else if (paddr_in == `VPIC_OFF_LVLL0)
				rdata_r <= {24'h000000, lvll_r[0]};
			else if (paddr_in == `VPIC_OFF_LVLH1)
				rdata_r <= {24'h000000, lvlh_r[1]};
			else if (paddr_in == `VPIC_OFF_LVLL1)
				rdata_r <= {24'h000000, lvll_r[1]};
			else if (paddr_in == `VPIC_OFF_LVLH2)
				rdata_r <= {24'h000000, lvlh_r[2]};
			else if (paddr_in == `VPIC_OFF_LVLL2)
				rdata_r <= {24'h000000, lvll_r[2]};
			else if (hit_ctrl)
				rdata_r <= {24'h000000, gate_r, 7'h00};
			else if (hit_stat)
				rdata_r <= {15'h0000, pend_r, vector_out}; // vector word, high byte at even address
			else
				rdata_r <= 32'h0000_0000;
		end
	end

endmodule

// ===== bench/vpic_ctrl_chk.sv
// port-level assertion checker for the interrupt controller
`timescale 1ns/1ns
module vpic_ctrl_chk (
	// clock, reset and handshakes
	input wire logic        clk_in, rst_n_in, psel_in, ack_in, irq_out, is_trap_out,
	// cpu strobes, watchdog and trap events
	input wire logic        enable_irqs_instruction_in, disable_irqs_instruction_in,
	input wire logic        return_from_isr_instruction_in, trap_instruction_in, wdt_irq_en_in,
	input wire logic        wdt_pulse_in, posc_fail_in, wosc_fail_in, ill_instr_in,
	// apb answer, gate and vector
	input wire logic        pready_out, pslverr_out, global_irq_gate_out,
	input wire logic [15:0] vector_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// clear events win over set events, so they gate the set check
	wire gclr = disable_irqs_instruction_in | trap_instruction_in | posc_fail_in | wosc_fail_in | ill_instr_in;
	sequence s_taken;
		irq_out && ack_in;
	endsequence
	sequence s_wdt_offer;
		irq_out && !is_trap_out && vector_out == 16'h0004;
	endsequence
	a_apb_answer: assert property (pready_out && !pslverr_out)
		else $error("apb answer not ready or error");
	a_offer_holds: assert property (irq_out && !ack_in |=> irq_out && $stable(vector_out))
		else $error("offer changed before ack");
	a_ack_ends_offer: assert property (s_taken |=> !irq_out)
		else $error("offer stayed after ack");
	a_ack_drops_gate: assert property (s_taken ##0 !is_trap_out |=> !global_irq_gate_out)
		else $error("gate stayed set after ack");
	a_gate_clear_evt: assert property (gclr |=> !global_irq_gate_out)
		else $error("gate stayed set after clear event");
	a_gate_set_evt: assert property ((enable_irqs_instruction_in || return_from_isr_instruction_in)
		&& !gclr && !psel_in && !irq_out |=> global_irq_gate_out)
		else $error("gate not set by instruction");
	a_gated_delivery: assert property ($rose(irq_out) && !is_trap_out && vector_out != 16'h0004
		|-> $past(global_irq_gate_out))
		else $error("interrupt offered with gate clear");
	a_trap_vectors: assert property (irq_out && is_trap_out |-> vector_out inside {16'h003a, 16'h003c, 16'h0006})
		else $error("trap on wrong vector");
	a_vector_legal: assert property (irq_out |-> !vector_out[0] && vector_out inside {[16'h0004:16'h0036], 16'h003a,
		16'h003c} && !(vector_out inside {16'h0008, 16'h0012, 16'h0014, [16'h0028:16'h002e]}))
		else $error("offered vector reserved or odd");
	a_wdt_first: assert property (wdt_pulse_in && wdt_irq_en_in && !irq_out |-> ##[1:3] s_wdt_offer)
		else $error("watchdog not offered first");
endmodule

// ===== bench/vpic_cpu_model.sv
// cpu model: takes each offered vector after a chosen delay
`timescale 1ns/1ns
module vpic_cpu_model (
	input wire logic        clk_in, irq_in,
	input wire logic [15:0] vec_in,
	input wire logic [2:0]  delay_in,
	output logic            ack_out = 0, taken_out = 0,
	output logic [15:0]     vec_out = 0
);
	int cnt = 0;
	// ack is held until the edge that takes the offer, then dropped
	always @(posedge clk_in) begin
		taken_out <= 0;
		if (irq_in && ack_out) begin
			ack_out <= 0;
			taken_out <= 1;
			vec_out <= vec_in;
			cnt <= 0;
		end else if (irq_in) begin
			cnt <= cnt + 1;
			if (cnt >= delay_in)
				ack_out <= 1;
		end
	end
endmodule

// ===== bench/vpic_ctrl_tb_top.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ns
`include "vpic_consts.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module vpic_ctrl_tb_top;
	logic        clk_in = 0, rst_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, wdt_irq_en_in = 1;
	logic [11:0] paddr_in = 0;
	logic [31:0] pwdata_in = 0;
	logic [7:0]  req0_pulse_in = 0, req1_pulse_in = 0, req2_pulse_in = 0, q;
	logic [3:0]  ev = 0, tp = 0;
	logic [2:0]  dly = 0;
	logic [23:0] hw, lw, rw;
	logic [15:0] v, tv [5] = '{16'h0004, 16'h003a, 16'h003c, 16'h0006, 16'h0000};
	wire  [31:0] prdata_out;
	wire  [15:0] vector_out, got;
	wire         pready_out, pslverr_out, irq_out, is_trap_out, global_irq_gate_out, ack_in, taken;
	// strobes packed so one task pulses any mix of them
	wire enable_irqs_instruction_in = ev[0], disable_irqs_instruction_in = ev[1];
	wire return_from_isr_instruction_in = ev[2], trap_instruction_in = ev[3];
	wire wdt_pulse_in = tp[3], posc_fail_in = tp[2], wosc_fail_in = tp[1], ill_instr_in = tp[0];
	int failures = 0, tests_run = 0, cyc = 0, sa, sb, la, lb;
	vpic_ctrl i_vpic_ctrl (.*);
	vpic_cpu_model i_vpic_cpu_model (.clk_in(clk_in), .irq_in(irq_out), .vec_in(vector_out), .delay_in(dly),
		.ack_out(ack_in), .taken_out(taken), .vec_out(got));
	initial forever #20 clk_in = ~clk_in;
	// hang guard, far above the under 2000 cycles of the run
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			finish_test;
		end
	end
	task finish_test;
		if (failures == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task apb(input bit w, input [11:0] a, input [7:0] d);
		@(posedge clk_in);
		psel_in <= 1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= {24'h0, d};
		@(posedge clk_in);
		penable_in <= 1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		q = prdata_out[7:0];
		psel_in <= 0;
		penable_in <= 0;
	endtask
	task pls(input [3:0] e, input [3:0] t, input [23:0] r);
		@(posedge clk_in);
		ev <= e;
		tp <= t;
		{req2_pulse_in, req1_pulse_in, req0_pulse_in} <= r;
		@(posedge clk_in);
		ev <= 0;
		tp <= 0;
		{req2_pulse_in, req1_pulse_in, req0_pulse_in} <= 0;
	endtask
	// vector taken by the cpu model, zero if none came
	task take;
		int i;
		@(posedge clk_in);
		for (i = 0; i < 16 && taken !== 1'b1; i++) @(posedge clk_in);
		v = taken === 1'b1 ? got : 16'h0000;
	endtask
	task chk_gate(input bit e);
		@(posedge clk_in);
		`CHK("gate", e, global_irq_gate_out)
	endtask
	// slot of source s, sources numbered in ranking order
	function automatic logic [15:0] svec(int s);
		if (s < 4) return 16'h000a + 16'(2 * s);
		if (s == 4) return 16'h0016;
		return s < 13 ? 16'h0018 + 16'(2 * (s - 5)) : 16'h0030 + 16'(2 * (s - 13));
	endfunction
	// bit of source s in {req2, req1, req0}
	function automatic int sbit(int s);
		if (s < 5) return s < 4 ? 6 - s : 0;
		return s < 13 ? 20 - s : 32 - s;
	endfunction
	initial begin
		void'($urandom(87166));
		repeat (12) @(posedge clk_in);
		rst_n_in <= 1;
		@(posedge clk_in);
		`CHK("vector", 16'h0002, vector_out)
		for (int r = 0; r < 3; r++) begin
			apb(1, 4 * r, 8'hff);
			apb(0, 4 * r, 0);
			`CHK("req", r == 0 ? 8'h7b : r == 1 ? 8'hff : 8'h0f, q)
			apb(1, 4 * r, 0);
			apb(0, 4 * r, 0);
			`CHK("req_clr", 8'h00, q)
		end
		apb(0, 12'h0fc, 0);
		`CHK("unmapped", 8'h00, q)
		// random source pairs and levels, pulses and software raises alternating
		for (int k = 0; k < 30; k++) begin
			sa = $urandom % 17;
			sb = (sa + 1 + $urandom % 16) % 17;
			la = $urandom % 4;
			lb = $urandom % 4;
			dly <= 3'($urandom % 4);
			{hw, lw, rw} = 0;
			{hw[sbit(sa)], lw[sbit(sa)], rw[sbit(sa)]} = {la[1:0], 1'b1};
			{hw[sbit(sb)], lw[sbit(sb)], rw[sbit(sb)]} = {lb[1:0], 1'b1};
			pls(4'h2, 0, 0);
			for (int r = 0; r < 3; r++) begin
				apb(1, 12'h00c + 8 * r, hw[8 * r +: 8]);
				apb(1, 12'h010 + 8 * r, lw[8 * r +: 8]);
				apb(1, 4 * r, k[0] ? rw[8 * r +: 8] : 8'h00);
			end
			if (!k[0]) pls(0, 0, rw);
			apb(0, 4 * (sbit(sa) / 8), 0);
			`CHK("pending", 1'b1, q[sbit(sa) % 8])
			`CHK("irq_gated", 1'b0, irq_out)
			pls(4'h1, 0, 0);
			take;
			`CHK("winner", (la | lb) == 0 ? 16'h0 : (la > lb || (la == lb && sa < sb)) ? svec(sa) : svec(sb), v)
			`CHK("gate_ack", v == 0, global_irq_gate_out)
		end
		// all watchdog and trap events at once, a level 3 pin waiting behind
		pls(4'h2, 0, 0);
		apb(1, `VPIC_OFF_REQ0, 0);
		apb(1, `VPIC_OFF_REQ1, 0);
		apb(1, `VPIC_OFF_LVLH2, 8'h01);
		apb(1, `VPIC_OFF_LVLL2, 8'h01);
		apb(1, `VPIC_OFF_REQ2, 8'h01);
		pls(0, 4'hf, 0);
		foreach (tv[i]) begin
			take;
			`CHK("trap_seq", tv[i], v)
		end
		pls(4'h1, 0, 0);
		take;
		`CHK("after_traps", 16'h0036, v)
		pls(4'h4, 0, 0);
		chk_gate(1);
		pls(4'h8, 0, 0);
		chk_gate(0);
		apb(1, `VPIC_OFF_CTRL, 8'h80);
		chk_gate(1);
		apb(1, `VPIC_OFF_CTRL, 8'h00);
		chk_gate(0);
		finish_test;
	end
endmodule
bind vpic_ctrl vpic_ctrl_chk i_vpic_ctrl_chk (.*);
